/* File: rtl/uart_status_params.svh */
`ifndef UART_STATUS_PARAMS_SVH
`define UART_STATUS_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_BAUD      8'h00
`define OFS_TXBUF     8'h04
`define OFS_RXBUF     8'h08
`define OFS_CTRL      8'h0C
`define OFS_MASK      8'h10
`define OFS_FLAGS     8'h14
`define OFS_GAP       8'h1C
`define OFS_TXFLUSH   8'h20
`define OFS_RXFLUSH   8'h24

// ****************************************
// event_flags bit positions
// ****************************************
`define BIT_TX_FULL    9
`define BIT_RX_HALF    8
`define BIT_GAP_EMPTY  7
`define BIT_GAP_HOLD   6
`define BIT_OVERFLOW   5
`define BIT_STOP_FAULT 4
`define BIT_PARITY     3
`define BIT_TX_HALF    2
`define BIT_SHIFT_IDLE 1
`define BIT_RX_DATA    0

// ****************************************
// port_control fields
// ****************************************
`define CTRL_WMASK    16'h05FF
`define CTRL_FIFOEN   10
`define CTRL_RXEN     8
`define CTRL_RUN      7
`define CTRL_LOOP     6
`define CTRL_PODD     5

// ****************************************
// reset values and levels
// ****************************************
`define BAUD_RESET    16'h0001
`define CTRL_RESET    16'h0000
`define MASK_RESET    9'h000
`define GAP_RESET     8'h00
`define FIFO_DEPTH    16
`define FIFO_FULL_LVL 5'h10
`define RX_HALF_LVL   5'h08
`define TX_HALF_LVL   5'h08

`endif

/* File: rtl/uart_status_pkg.sv */
`default_nettype none

package uart_status_pkg;
    // receive gap watchdog
    typedef enum logic {GAP_IDLE, GAP_COUNT} gap_state_t;
    typedef logic [15:0] reg_word_t;
endpackage

`default_nettype wire

/* File: rtl/char_fifo.sv */
`default_nettype none

module char_fifo #(
    parameter int W  = 11,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          flush,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic      [W-1:0]  head,
    output logic      [AW:0]   count,
    output logic      [1:0]    flag_or
);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    wire           full  = (cnt_r == (AW+1)'(D));
    wire           empty = (cnt_r == '0);
    wire           do_push = push & ~full;   // a push into a full buffer is lost
    wire           do_pop  = pop & ~empty;

    assign head  = mem_r[rd_r];
    assign count = cnt_r;

    // top two bits of every occupied entry, ORed
    always_comb begin
        logic [AW-1:0] off;
        off     = '0;
        flag_or = 2'h0;
        for (int i = 0; i < D; i++) begin
            off = AW'(i) - rd_r;
            if ({1'b0, off} < cnt_r) begin
                flag_or = flag_or | mem_r[i][W-1:W-2];
            end
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_r[wr_r] <= push_data;
        end
    end

    // pointers; flush wins over both ports
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (flush) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_r + AW'(do_push);
            rd_r  <= rd_r + AW'(do_pop);
            cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // char_fifo

`default_nettype wire

/* File: rtl/uart_irq_status.sv */
// How it works
// - interrupt output high while any of flags 0..8 and its mask bit are both 1; flag 9 has no mask bit
// - mask register holds nine enables, bits 0..8, one per flag position
// - flag 9 reads 1 exactly when transmit buffer holds 16 characters
// - flag 8 reads 1 while receive buffer holds eight or more characters
// - flag 7 set when gap watchdog expires with receive buffer empty
// - flag 6 set when gap watchdog expires with receive buffer holding data
// - flag 5 set when a character completes while receive buffer is full
// - flag 4 reads 1 while a buffered character carries a stop-bit fault
// - flag 3 reads 1 while a buffered character carries a parity fault
// - flag 2 reads 1 while at least half the transmit buffer is free
// - flag 1 reads 1 while the transmit shifter is idle
// - flag 0 reads 1 while the receive buffer holds at least one entry
// - flags read 0x0006 after reset
// - gap register gives an 8-bit watchdog period in baud ticks
// - any write to the receive flush register empties the receive buffer
// - no shifting and no gap counting while the run bit is 0
`include "uart_status_params.svh"
`default_nettype none

module uart_irq_status (
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // controls toward the shift engines
    output logic             BAUD_TICK,
    output logic             RUN,
    output logic             RX_ENABLE,
    output logic             FIFO_ENABLE,
    output logic             LOOP_BACK,
    output logic             PARITY_ODD,
    output logic      [1:0]  STOP_BITS,
    output logic      [2:0]  MODE,
    // transmit side
    output logic      [8:0]  TX_CHAR,
    output logic             TX_CHAR_VALID,
    input  wire logic        TX_CHAR_TAKE,
    input  wire logic        TX_SHIFTER_IDLE,
    // receive side
    input  wire logic [8:0]  RX_CHAR,
    input  wire logic        RX_STOP_FAULT,
    input  wire logic        RX_PARITY_FAULT,
    input  wire logic        RX_CHAR_DONE,
    // interrupt
    output logic             INTERRUPT
);

    // ****************************************
    // register decode
    // ****************************************

    // one strobe per register, taken straight from the port
    wire wr_baud    = WR & (ADDR == `OFS_BAUD);
    wire wr_txbuf   = WR & (ADDR == `OFS_TXBUF);
    wire wr_ctrl    = WR & (ADDR == `OFS_CTRL);
    wire wr_mask    = WR & (ADDR == `OFS_MASK);
    wire wr_gap     = WR & (ADDR == `OFS_GAP);
    wire wr_txflush = WR & (ADDR == `OFS_TXFLUSH);
    wire wr_rxflush = WR & (ADDR == `OFS_RXFLUSH);
    wire rd_rxbuf   = RD & (ADDR == `OFS_RXBUF);
    wire rd_flags   = RD & (ADDR == `OFS_FLAGS);

    // ****************************************
    // software registers
    // ****************************************

    // mask and gap keep only their implemented bits; control keeps bits 0..8 and 10
    logic [15:0] ctrl_r;
    logic [8:0]  mask_r;
    logic [7:0]  gap_period_r;

    // reserved bits are dropped or masked to zero on write, so they read back as zero
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_r       <= `CTRL_RESET;
            mask_r       <= `MASK_RESET;
            gap_period_r <= `GAP_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= WDATA & `CTRL_WMASK;
            end
            if (wr_mask) begin
                mask_r <= WDATA[8:0];
            end
            if (wr_gap) begin
                gap_period_r <= WDATA[7:0];
            end
        end
    end

    // control fields fanned out to the shift engines
    assign RUN         = ctrl_r[`CTRL_RUN];
    assign RX_ENABLE   = ctrl_r[`CTRL_RXEN];
    assign FIFO_ENABLE = ctrl_r[`CTRL_FIFOEN];
    assign LOOP_BACK   = ctrl_r[`CTRL_LOOP];
    assign PARITY_ODD  = ctrl_r[`CTRL_PODD];
    assign STOP_BITS   = ctrl_r[4:3];
    assign MODE        = ctrl_r[2:0];

    // ****************************************
    // baud generator
    // ****************************************

    logic [15:0] reload_r;
    logic [15:0] baud_cnt_r;
    logic        reload_pend_r;
    logic        tick_r;

    // a reload written while stopped waits for the first running cycle
    wire baud_zero = (baud_cnt_r == 16'h0000);

    // counter only moves while running; the tick is a one-cycle enable
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            reload_r      <= `BAUD_RESET;
            baud_cnt_r    <= `BAUD_RESET;
            reload_pend_r <= 1'b0;
            tick_r        <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (wr_baud) begin
                reload_r <= WDATA;
            end
            if (wr_baud && RUN) begin
                baud_cnt_r    <= WDATA;
                reload_pend_r <= 1'b0;
            end else if (wr_baud) begin
                reload_pend_r <= 1'b1;
            end else if (RUN && reload_pend_r) begin
                baud_cnt_r    <= reload_r;
                reload_pend_r <= 1'b0;
            end else if (RUN && baud_zero) begin
                baud_cnt_r <= reload_r;
                tick_r     <= 1'b1;
            end else if (RUN) begin
                baud_cnt_r <= baud_cnt_r - 16'h0001;
            end
        end
    end

    // registered, so the enable reaches the shift engines glitch free
    assign BAUD_TICK = tick_r;

    // ****************************************
    // character buffers
    // ****************************************

    logic [8:0]  tx_head;
    logic [4:0]  tx_count;
    logic [10:0] rx_head;
    logic [4:0]  rx_count;
    logic [1:0]  rx_faults;
    logic [1:0]  tx_spare;     // fault slots, always zero on transmit

    // writes past a full transmit buffer are dropped
    char_fifo #(
        .W  (11),
        .D  (`FIFO_DEPTH),
        .AW (4)
    ) u_tx_fifo (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .flush     (wr_txflush),
        .push      (wr_txbuf),
        .push_data ({2'h0, WDATA[8:0]}),
        .pop       (TX_CHAR_TAKE),
        .head      ({tx_spare, tx_head}),
        .count     (tx_count),
        .flag_or   ()
    );

    // faults travel with each character so they clear as it is read
    char_fifo #(
        .W  (11),
        .D  (`FIFO_DEPTH),
        .AW (4)
    ) u_rx_fifo (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .flush     (wr_rxflush),
        .push      (RX_CHAR_DONE),
        .push_data ({RX_STOP_FAULT, RX_PARITY_FAULT, RX_CHAR}),
        .pop       (rd_rxbuf),
        .head      (rx_head),
        .count     (rx_count),
        .flag_or   (rx_faults)
    );

    // head stands until the shifter pops it with its take pulse
    assign TX_CHAR       = tx_head;
    assign TX_CHAR_VALID = (tx_count != 5'h00);

    // ****************************************
    // receive gap watchdog
    // ****************************************

    uart_status_pkg::gap_state_t gap_state_r;
    uart_status_pkg::gap_state_t gap_state_nxt;
    logic [7:0] gap_cnt_r;
    logic [7:0] gap_cnt_nxt;

    // a zero period disarms the watchdog rather than firing at once
    wire gap_step = RUN & tick_r & (gap_period_r != 8'h00);
    wire gap_last = ((gap_cnt_r + 8'h01) == gap_period_r);
    wire gap_fire = (gap_state_r == uart_status_pkg::GAP_COUNT)
                  & gap_step & gap_last & ~RX_CHAR_DONE;

    // restart on every character, stop after one expiry
    always_comb begin
        gap_state_nxt = gap_state_r;
        gap_cnt_nxt   = gap_cnt_r;
        case (gap_state_r)
            uart_status_pkg::GAP_IDLE: begin
                if (RX_CHAR_DONE) begin
                    gap_state_nxt = uart_status_pkg::GAP_COUNT;
                    gap_cnt_nxt   = 8'h00;
                end
            end
            uart_status_pkg::GAP_COUNT: begin
                if (RX_CHAR_DONE) begin
                    gap_cnt_nxt = 8'h00;
                end else if (gap_fire) begin
                    gap_state_nxt = uart_status_pkg::GAP_IDLE;
                    gap_cnt_nxt   = 8'h00;
                end else if (gap_step) begin
                    gap_cnt_nxt = gap_cnt_r + 8'h01;
                end
            end
            default: begin
                gap_state_nxt = uart_status_pkg::GAP_IDLE;
                gap_cnt_nxt   = 8'h00;
            end
        endcase
    end

    // watchdog state and tick count
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            gap_state_r <= uart_status_pkg::GAP_IDLE;
            gap_cnt_r   <= 8'h00;
        end else begin
            gap_state_r <= gap_state_nxt;
            gap_cnt_r   <= gap_cnt_nxt;
        end
    end

    // ****************************************
    // sticky event flags
    // ****************************************

    logic gap_empty_r;
    logic gap_hold_r;
    logic overflow_r;

    // a new event in the clearing read cycle survives the read
    wire rx_empty      = (rx_count == 5'h00);
    wire rx_full       = (rx_count == `FIFO_FULL_LVL);
    wire set_gap_empty = gap_fire & rx_empty;
    wire set_gap_hold  = gap_fire & ~rx_empty;
    wire set_overflow  = RX_CHAR_DONE & rx_full;

    wire gap_empty_nxt = set_gap_empty | (gap_empty_r & ~rd_flags);
    wire gap_hold_nxt  = set_gap_hold | (gap_hold_r & ~rd_flags);
    wire overflow_nxt  = set_overflow | (overflow_r & ~rd_flags);

    // only a read of event_flags clears these three
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            gap_empty_r <= 1'b0;
            gap_hold_r  <= 1'b0;
            overflow_r  <= 1'b0;
        end else begin
            gap_empty_r <= gap_empty_nxt;
            gap_hold_r  <= gap_hold_nxt;
            overflow_r  <= overflow_nxt;
        end
    end

    // ****************************************
    // event_flags assembly
    // ****************************************

    // level flags follow buffer state; empty buffers give 0x0006
    logic [15:0] flags;
    assign flags[15:10]            = 6'h00;
    assign flags[`BIT_TX_FULL]     = (tx_count == `FIFO_FULL_LVL);
    assign flags[`BIT_RX_HALF]     = (rx_count >= `RX_HALF_LVL);
    assign flags[`BIT_GAP_EMPTY]   = gap_empty_r;
    assign flags[`BIT_GAP_HOLD]    = gap_hold_r;
    assign flags[`BIT_OVERFLOW]    = overflow_r;
    assign flags[`BIT_STOP_FAULT]  = rx_faults[1];
    assign flags[`BIT_PARITY]      = rx_faults[0];
    assign flags[`BIT_TX_HALF]     = (tx_count <= `TX_HALF_LVL);
    assign flags[`BIT_SHIFT_IDLE]  = TX_SHIFTER_IDLE;
    assign flags[`BIT_RX_DATA]     = ~rx_empty;

    // level output, no extra latency
    assign INTERRUPT = |(flags[8:0] & mask_r);

    // ****************************************
    // read path
    // ****************************************

    // write-only and unmapped offsets read as zero
    uart_status_pkg::reg_word_t rd_sel;
    uart_status_pkg::reg_word_t rdata_r;

    // an empty buffer reads zero rather than stale storage
    wire [15:0] rxbuf_word = rx_empty ? 16'h0000
                           : {6'h00, rx_head[10], rx_head[8:0]};

    // the baud offset shows the live counter, not the reload
    assign rd_sel = (ADDR == `OFS_BAUD)  ? baud_cnt_r
                  : (ADDR == `OFS_RXBUF) ? rxbuf_word
                  : (ADDR == `OFS_CTRL)  ? ctrl_r
                  : (ADDR == `OFS_MASK)  ? {7'h00, mask_r}
                  : (ADDR == `OFS_FLAGS) ? flags
                  : (ADDR == `OFS_GAP)   ? {8'h00, gap_period_r}
                  : 16'h0000;

    // data stands only in the cycle after the read strobe
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= RD ? rd_sel : 16'h0000;
        end
    end

    // flop output keeps the bus free of decode glitches
    assign RDATA = rdata_r;

endmodule // uart_irq_status

`default_nettype wire

/* File: tb/uart_irq_status_properties.sv */
`include "uart_status_params.svh"
`default_nettype none
// ****************************************
// register port and status checks
// ****************************************
module uart_irq_status_properties (
    input wire logic        CORE_CLK,
    input wire logic        NRST,
    input wire logic [7:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        BAUD_TICK,
    input wire logic        RUN,
    input wire logic        TX_CHAR_VALID,
    input wire logic        TX_SHIFTER_IDLE,
    input wire logic        RX_CHAR_DONE,
    input wire logic        INTERRUPT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] mask_r;
    logic [7:0] gap_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    // shadows of what software wrote, so readback has an independent reference
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_r <= 9'h000;
            gap_r  <= 8'h00;
        end else if (WR && ADDR == `OFS_MASK) begin
            mask_r <= WDATA[8:0];
        end else if (WR && ADDR == `OFS_GAP) begin
            gap_r <= WDATA[7:0];
        end
    end

    mask_quiet_a: assert property (mask_r == 9'h000 |-> !INTERRUPT)
        else $error("interrupt high with every source masked");
    idle_irq_a: assert property ((TX_SHIFTER_IDLE && mask_r[1]) [*3] |-> INTERRUPT)
        else $error("idle shifter with enable set gave no interrupt");
    mask_read_a: assert property (RD && ADDR == `OFS_MASK |=> RDATA == {7'h00, $past(mask_r)})
        else $error("interrupt enables read back wrong");
    gap_read_a: assert property (RD && ADDR == `OFS_GAP |=> RDATA == {8'h00, $past(gap_r)})
        else $error("gap period read back wrong");
    tx_flush_a: assert property (WR && ADDR == `OFS_TXFLUSH |=> !TX_CHAR_VALID)
        else $error("transmit buffer not empty after flush");
    rx_flush_a: assert property ((WR && ADDR == `OFS_RXFLUSH) ##1 !RX_CHAR_DONE
        ##1 (RD && ADDR == `OFS_FLAGS && !RX_CHAR_DONE) |=> !RDATA[0])
        else $error("receive buffer not empty after flush");
    rx_data_a: assert property ((RX_CHAR_DONE && !(WR && ADDR == `OFS_RXFLUSH))
        ##1 (!WR && !RD) ##1 (RD && ADDR == `OFS_FLAGS) |=> RDATA[0])
        else $error("received character not flagged");
    baud_halt_a: assert property (!RUN && !$past(RUN) |-> !BAUD_TICK)
        else $error("baud tick while generator stopped");
endmodule // uart_irq_status_properties
`default_nettype wire

/* File: tb/line_partner.sv */
`default_nettype none
// ****************************************
// far-side shift engine stand-in
// ****************************************
module line_partner (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic [8:0] tx_char,
    input  wire logic       tx_valid,
    output logic            tx_take,
    output logic            shifter_idle,
    output logic      [8:0] rx_char,
    output logic            rx_stop,
    output logic            rx_parity,
    output logic            rx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] sent_q[$];
    int         busy_cnt;

    // receive lines idle low-activity until a character is sent
    initial begin
        rx_char   = 9'h000;
        rx_stop   = 1'b0;
        rx_parity = 1'b0;
        rx_done   = 1'b0;
    end

    // one character at a time; a long busy spell exposes the idle flag
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_take      <= 1'b0;
            shifter_idle <= 1'b1;
            busy_cnt     <= 0;
        end else if (tx_take) begin
            tx_take <= 1'b0;
        end else if (busy_cnt > 0) begin
            busy_cnt     <= busy_cnt - 1;
            shifter_idle <= (busy_cnt == 1);
        end else if (tx_valid && !stall) begin
            tx_take      <= 1'b1;
            busy_cnt     <= 20;
            shifter_idle <= 1'b0;
            sent_q.push_back(tx_char);
        end
    end

    // lines invert after the pulse so stale data never looks valid
    task automatic send_char(input logic [8:0] c, input logic sf, input logic pf);
        @(posedge clk);
        rx_char   <= c;
        rx_stop   <= sf;
        rx_parity <= pf;
        rx_done   <= 1'b1;
        @(posedge clk);
        rx_done   <= 1'b0;
        rx_char   <= ~c;
        rx_stop   <= ~sf;
        rx_parity <= ~pf;
    endtask
endmodule // line_partner
`default_nettype wire

/* File: tb/uart_irq_status_test.sv */
`include "uart_status_params.svh"
`default_nettype none
// ****************************************
// register level bench
// ****************************************
module uart_irq_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    localparam row_t ROWS [10] = '{
        '{8'h10, 16'hFFFF, 16'h01FF}, '{8'h10, 16'h0155, 16'h0155},
        '{8'h1C, 16'hFFFF, 16'h00FF}, '{8'h1C, 16'h00A5, 16'h00A5},
        '{8'h0C, 16'hFFFF, 16'h05FF}, '{8'h0C, 16'h0000, 16'h0000},
        '{8'h18, 16'h1234, 16'h0000}, '{8'h20, 16'hFFFF, 16'h0000},
        '{8'h24, 16'hFFFF, 16'h0000}, '{8'h14, 16'hFFFF, 16'h0006}};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic        stall = 1'b0;
    logic [15:0] rdata;
    logic [15:0] v;
    logic [8:0]  tx_char;
    logic [8:0]  rx_char;
    logic        tx_valid, tx_take, idle, rx_stop, rx_par, rx_done, irq, tick;
    wire  [9:0]  ctl;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          i;

    always #4 clk = ~clk;

    uart_irq_status uart_irq_status_i (
        .CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr_strobe),
        .RD(rd_strobe), .RDATA(rdata), .BAUD_TICK(tick), .RUN(ctl[7]),
        .RX_ENABLE(ctl[8]), .FIFO_ENABLE(ctl[9]), .LOOP_BACK(ctl[6]), .PARITY_ODD(ctl[5]),
        .STOP_BITS(ctl[4:3]), .MODE(ctl[2:0]), .TX_CHAR(tx_char),
        .TX_CHAR_VALID(tx_valid), .TX_CHAR_TAKE(tx_take), .TX_SHIFTER_IDLE(idle),
        .RX_CHAR(rx_char), .RX_STOP_FAULT(rx_stop), .RX_PARITY_FAULT(rx_par),
        .RX_CHAR_DONE(rx_done), .INTERRUPT(irq));

    line_partner line_partner_i (
        .clk(clk), .nrst(nrst), .stall(stall), .tx_char(tx_char), .tx_valid(tx_valid),
        .tx_take(tx_take), .shifter_idle(idle), .rx_char(rx_char), .rx_stop(rx_stop),
        .rx_parity(rx_par), .rx_done(rx_done));

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // the #1 lets the edge's register updates land before anything is sampled
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_strobe <= 1'b1;
        addr      <= a;
        wdata     <= d;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_strobe <= 1'b1;
        addr      <= a;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // hang guard, well above the roughly 1500 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up;
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(`OFS_FLAGS, v);
        check_word(v, 16'h0006);
        rd(`OFS_MASK, v);
        check_word(v, 16'h0000);
        rd(`OFS_GAP, v);
        check_word(v, 16'h0000);
        foreach (ROWS[k]) begin
            wr(ROWS[k].a, ROWS[k].d);
            rd(ROWS[k].a, v);
            check_word(v, ROWS[k].e);
        end
        // control fields fanned out, run bit left clear
        wr(`OFS_CTRL, 16'h0569);
        check_word({6'h00, ctl}, 16'h0369);
        wr(`OFS_CTRL, 16'h0000);
        // transmit fill with the far side stalled, then flush
        stall <= 1'b1;
        for (i = 1; i <= 16; i++) begin
            wr(`OFS_TXBUF, 16'(i));
            rd(`OFS_FLAGS, v);
            check_bit(v[`BIT_TX_FULL], i == 16);
            check_bit(v[`BIT_TX_HALF], i <= 8);
        end
        wr(`OFS_TXBUF, 16'h0077);
        wr(`OFS_TXFLUSH, 16'h0000);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h0206, 16'h0006);
        stall <= 1'b0;
        wr(`OFS_TXBUF, 16'h015A);
        wr(`OFS_TXBUF, 16'h00A5);
        rd(`OFS_FLAGS, v);
        check_bit(v[`BIT_SHIFT_IDLE], 1'b0);
        wait_cycles(60);
        rd(`OFS_FLAGS, v);
        check_bit(v[`BIT_SHIFT_IDLE], 1'b1);
        check_word(16'(line_partner_i.sent_q.size()), 16'h0002);
        check_word({7'h00, line_partner_i.sent_q[0]}, 16'h015A);
        // receive faults, level, overflow and flush
        line_partner_i.send_char(9'h1C3, 1'b0, 1'b1);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h0019, 16'h0009);
        rd(`OFS_RXBUF, v);
        check_word(v, 16'h01C3);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h0019, 16'h0000);
        line_partner_i.send_char(9'h055, 1'b1, 1'b0);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h0019, 16'h0011);
        rd(`OFS_RXBUF, v);
        check_word(v, 16'h0255);
        for (i = 1; i <= 17; i++) begin
            line_partner_i.send_char(9'(i), 1'b0, 1'b0);
            rd(`OFS_FLAGS, v);
            check_word({14'h0, v[`BIT_RX_HALF], v[`BIT_OVERFLOW]}, {14'h0, i >= 8, i == 17});
        end
        wr(`OFS_RXFLUSH, 16'hFFFF);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h0119, 16'h0000);
        // gap watchdog: halted, restarted, expired holding and empty
        wr(`OFS_BAUD, 16'h0040);
        wr(`OFS_GAP, 16'h0004);
        line_partner_i.send_char(9'h011, 1'b0, 1'b0);
        wait_cycles(400);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h00C1, 16'h0001);
        wr(`OFS_CTRL, 16'h0080);
        line_partner_i.send_char(9'h022, 1'b0, 1'b0);
        wait_cycles(150);
        line_partner_i.send_char(9'h033, 1'b0, 1'b0);
        wait_cycles(110);
        rd(`OFS_FLAGS, v);
        check_bit(v[`BIT_GAP_HOLD], 1'b0);
        wait_cycles(170);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h00C0, 16'h0040);
        wr(`OFS_RXFLUSH, 16'h0000);
        line_partner_i.send_char(9'h044, 1'b0, 1'b0);
        rd(`OFS_RXBUF, v);
        wait_cycles(300);
        rd(`OFS_FLAGS, v);
        check_word(v & 16'h00C1, 16'h0080);
        // interrupt masking per source
        wr(`OFS_MASK, 16'h0001);
        check_bit(irq, 1'b0);
        line_partner_i.send_char(9'h055, 1'b0, 1'b0);
        wait_cycles(1);
        check_bit(irq, 1'b1);
        wr(`OFS_MASK, 16'h0002);
        wait_cycles(3);
        check_bit(irq, 1'b1);
        wr(`OFS_MASK, 16'h0000);
        check_bit(irq, 1'b0);
        wrap_up;
    end
endmodule // uart_irq_status_test

bind uart_irq_status uart_irq_status_properties uart_irq_status_properties_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .BAUD_TICK(BAUD_TICK), .RUN(RUN), .TX_CHAR_VALID(TX_CHAR_VALID),
    .TX_SHIFTER_IDLE(TX_SHIFTER_IDLE), .RX_CHAR_DONE(RX_CHAR_DONE), .INTERRUPT(INTERRUPT));
`default_nettype wire
